/* core/hsc_ctrl.sv */
/*
  Controller that drives a humidity and temperature sensor over its serial
  bus as bus master, takes orders over AXI4-Lite and reports results.
  Assumes external pull-ups on both bus lines and a sensor that keeps its
  own side of the bus protocol.
*/
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
// Notes on behaviour
// R1: Serial clock may run at any rate up to 1000 kHz, including stretched.
// R2: Sensor stretches the clock low for stretching commands while not ready.
// R3: Lines are only pulled low; pull-ups make the high level.
// R4: Sensor answers 0x44 with select low, 0x45 with select high.
// R5: Address select stays constant from start until the transaction ends.
// R6: Sensor follows address select changes between transactions without reset.
// R7: Upper seven header bits are the address, lowest bit is direction.
// R8: Alarm output is high while the latest reading meets the limit condition.
// R9: Hard reset is a low pulse of at least 1 us.
// R10: At least 1 ms must pass between two commands.
// R11: Each command is a 16-bit word with a 3-bit checksum inside.
// R12: Every data word in either direction is followed by an 8-bit checksum.
// R13: Written data carries its checksum; the sensor drops data with bad checksum.
// R14: The master may choose to read and check returned checksums.
// R15: Sensor waits the power-up delay before it accepts commands.
// R16: Every transaction opens with START and closes with STOP.
// R17: Sensor idles by itself when neither measuring nor communicating.
// R18: Measurement starts with START, write header, then two command bytes.
// R19: Sensor acknowledges each byte after the falling edge of the 8th clock.
// R20: Sensor starts measuring when it acknowledges the measurement command.
// R21: Measurement ends within 4, 6 or 15 ms by repeatability.
// R22: Results come as temperature word first, then humidity word.
// R23: Stretching read: header acknowledged, clock held low until results ready.
// R24: Non-stretching read: header not acknowledged while no result is ready.
// R25: Sensor ignores headers whose address does not match its own.
`timescale 1ns/1ps
`include "hsc_consts.svh"

module hsc_ctrl
  import hsc_pkg::*;
#(
  parameter int unsigned GAP_CYC = (`HSC_GAP_NS * `HSC_CLK_MHZ) / 1000
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic bus_address_select_o,
  output logic hard_reset_input_low_o,
  input wire logic limit_alarm_output_i
);
  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  hsc_state_t st_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [2:0] idx_q;
  logic rd_q, scl_low_q, sda_low_q, ack_q, nack_q, done_q, nrst_q;
  logic [7:0] tx_q;
  logic [47:0] rx_q;
  logic [`HSC_WAIT_W-1:0] wait_q;
  logic [`HSC_QTR_W-1:0] div_q;
  logic [15:0] cmd_q, temp_q, hum_q;
  logic addr_sel_q, crc_err_q, valid_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic scl_s, sda_s, alert_s;
  logic [7:0] crc_t, crc_h;
  logic idle, tick, hold, step, tx_ph, slot, wr_fire, w_ok, ctrl_wr;
  logic go_meas, go_read, go_rst;

  // --------------------------------------------------------------------------
  // Pin synchronisers and checksums
  // --------------------------------------------------------------------------
  hsc_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i(scl_i),
    .q_o(scl_s)
  );
  hsc_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i(sda_i),
    .q_o(sda_s)
  );
  hsc_sync #(.RST_VAL(1'b0)) u_alert_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i(limit_alarm_output_i),
    .q_o(alert_s)
  );
  hsc_crc8 u_crc_temp (
    .data_i(rx_q[47:32]),
    .crc_o(crc_t)
  );
  hsc_crc8 u_crc_hum (
    .data_i(rx_q[23:8]),
    .crc_o(crc_h)
  );

  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  // Address and data are taken together, so a lone channel simply waits.
  assign idle = (st_q == ST_IDLE);
  assign wr_fire = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_q;
  assign s_axi_awready_o = wr_fire;
  assign s_axi_wready_o = wr_fire;
  assign w_ok = idle && ((s_axi_awaddr_i == `HSC_OFS_CTRL) || (s_axi_awaddr_i == `HSC_OFS_CMD));
  assign ctrl_wr = wr_fire && idle && (s_axi_awaddr_i == `HSC_OFS_CTRL) && s_axi_wstrb_i[0];
  assign go_rst = ctrl_wr && s_axi_wdata_i[`HSC_CTRL_RST];
  assign go_meas = ctrl_wr && s_axi_wdata_i[`HSC_CTRL_MEAS] && !go_rst;
  assign go_read = ctrl_wr && s_axi_wdata_i[`HSC_CTRL_READ] && !go_rst && !go_meas;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= `HSC_RESP_OK;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= w_ok ? `HSC_RESP_OK : `HSC_RESP_ERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // Settings change only while idle, so the select line cannot move mid-frame.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      addr_sel_q <= 1'b0;
      cmd_q <= 16'h0000;
    end else if (wr_fire && idle) begin
      if (ctrl_wr) begin
        addr_sel_q <= s_axi_wdata_i[`HSC_CTRL_ASEL]; // [R5]
      end
      if (s_axi_awaddr_i == `HSC_OFS_CMD) begin
        if (s_axi_wstrb_i[0]) begin
          cmd_q[7:0] <= s_axi_wdata_i[7:0];
        end
        if (s_axi_wstrb_i[1]) begin
          cmd_q[15:8] <= s_axi_wdata_i[15:8];
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rresp_q <= `HSC_RESP_OK;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid_i && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= `HSC_RESP_OK;
      case (s_axi_araddr_i)
        `HSC_OFS_CTRL: rdata_q <= 32'(addr_sel_q) << `HSC_CTRL_ASEL;
        `HSC_OFS_CMD: rdata_q <= {16'h0000, cmd_q};
        `HSC_OFS_STAT: rdata_q <= {27'h0000000, valid_q, alert_s, crc_err_q, nack_q, !idle};
        `HSC_OFS_DATA: rdata_q <= {temp_q, hum_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `HSC_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Serial bus engine
  // --------------------------------------------------------------------------
  // Lines are only ever pulled low; the enables carry all the drive. [R3]
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_low_q;
  assign sda_oe_o = sda_low_q;
  assign bus_address_select_o = addr_sel_q;
  assign hard_reset_input_low_o = nrst_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tick = (div_q == `HSC_QTR_W'(`HSC_QTR_CYC - 1));
  // A released clock that still reads low is the sensor stretching it. [R1]
  assign hold = !scl_s && !scl_low_q && (ph_q == ((st_q == ST_START) ? 2'h1 : 2'h2));
  assign step = tick && !hold;
  assign tx_ph = (idx_q == 3'h0) || !rd_q;
  assign slot = (bit_q == `HSC_BIT_ACK);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      idx_q <= 3'h0;
      rd_q <= 1'b0;
      tx_q <= 8'h00;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      wait_q <= '0;
      nrst_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      if (step) begin
        ph_q <= ph_q + 2'h1;
      end
      case (st_q)
        ST_IDLE: begin
          ph_q <= 2'h0;
          if (go_rst) begin
            st_q <= ST_RST;
            nrst_q <= 1'b0;
            wait_q <= '0;
          end else if (go_meas || go_read) begin
            st_q <= ST_START;
            rd_q <= go_read;
            idx_q <= 3'h0;
            nack_q <= 1'b0;
          end
        end
        ST_RST: begin
          wait_q <= wait_q + 1'b1;
          if (wait_q == `HSC_WAIT_W'(`HSC_RST_CYC - 1)) begin
            nrst_q <= 1'b1; // [R9]
            st_q <= ST_GAP;
            wait_q <= '0;
          end
        end
        // After a command or a reset the sensor needs this quiet time. [R10]
        ST_GAP: begin
          wait_q <= wait_q + 1'b1;
          if (wait_q == `HSC_WAIT_W'(GAP_CYC - 1)) begin
            st_q <= ST_IDLE;
          end
        end
        ST_START: if (step) begin
          case (ph_q)
            2'h0: begin
              scl_low_q <= 1'b0;
              sda_low_q <= 1'b0;
            end
            2'h1: sda_low_q <= 1'b1; // [R16]
            2'h2: scl_low_q <= 1'b1;
            default: begin
              st_q <= ST_BIT;
              bit_q <= 4'h0;
              tx_q <= {(addr_sel_q ? `HSC_ADDR_HI : `HSC_ADDR_LO), rd_q}; // [R18]
            end
          endcase
        end
        ST_BIT: if (step) begin
          case (ph_q)
            2'h0: begin
              if (!slot) begin
                sda_low_q <= tx_ph && !tx_q[7];
              end else begin
                // Acknowledge every data byte but the last, which ends the read. [R14]
                sda_low_q <= !tx_ph && (idx_q != `HSC_LAST_RD);
              end
            end
            2'h1: scl_low_q <= 1'b0;
            2'h2: ack_q <= sda_s;
            default: begin
              scl_low_q <= 1'b1;
              if (!slot) begin
                bit_q <= bit_q + 4'h1;
                tx_q <= tx_q << 1;
              end else begin
                bit_q <= 4'h0;
                if (tx_ph && ack_q) begin
                  nack_q <= 1'b1;
                  st_q <= ST_STOP;
                end else if (idx_q == (rd_q ? `HSC_LAST_RD : `HSC_LAST_WR)) begin
                  st_q <= ST_STOP;
                end else begin
                  idx_q <= idx_q + 3'h1;
                  // The command word already holds its own checksum. [R13]
                  tx_q <= (idx_q == 3'h0) ? cmd_q[15:8] : cmd_q[7:0];
                end
              end
            end
          endcase
        end
        ST_STOP: if (step) begin
          case (ph_q)
            2'h0: sda_low_q <= 1'b1;
            2'h1: scl_low_q <= 1'b0;
            2'h2: sda_low_q <= 1'b1;
            default: begin
              sda_low_q <= 1'b0; // [R16]
              st_q <= ST_GAP;
              wait_q <= '0;
              done_q <= rd_q && !nack_q;
            end
          endcase
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Received bits, temperature word first, each word followed by its checksum.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_q <= 48'h0000_0000_0000;
    end else if (st_q == ST_BIT && step && ph_q == 2'h2 && !tx_ph && !slot) begin
      rx_q <= {rx_q[46:0], sda_s};
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      temp_q <= 16'h0000;
      hum_q <= 16'h0000;
      crc_err_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (done_q) begin
      temp_q <= rx_q[47:32];
      hum_q <= rx_q[23:8];
      crc_err_q <= (crc_t != rx_q[31:24]) || (crc_h != rx_q[7:0]); // [R12]
      valid_q <= 1'b1;
    end else if (go_read) begin
      crc_err_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic [7:0] rl_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rl_q <= 8'h00;
    end else if (nrst_q) begin
      rl_q <= 8'h00;
    end else if (rl_q != 8'hff) begin
      rl_q <= rl_q + 8'h01;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  chk_open_drain: assert property (!scl_o && !sda_o && (sda_oe_o == sda_low_q)) // [R3]
    else $error("bus line driven high");
  chk_addr_hold: assert property (!idle && !$past(idle) |-> $stable(bus_address_select_o)) // [R5]
    else $error("address select moved during a transaction");
  chk_reset_len: assert property ($rose(nrst_q) |-> $past(rl_q) >= 8'(`HSC_RST_CYC - 1)) // [R9]
    else $error("hard reset pulse too short");
  chk_cmd_gap: assert property ($rose(idle) |-> $past(wait_q) == `HSC_WAIT_W'(GAP_CYC - 1)) // [R10]
    else $error("command spacing not kept");
  chk_start_cond: assert property ($rose(sda_low_q) && !scl_low_q |-> st_q == ST_START) // [R16]
    else $error("data fell with clock high outside start");
  chk_stop_cond: assert property ($fell(sda_low_q) && !scl_low_q |-> st_q == ST_GAP) // [R16]
    else $error("data rose with clock high outside stop");
  chk_write_bit: assert property (st_q == ST_BIT && idx_q == 3'h0 && bit_q == 4'h7 // [R18]
    && ph_q == 2'h1 |-> sda_low_q == !rd_q)
    else $error("header direction bit wrong");
  // Only a write sends the command; a read releases the data line instead.
  chk_cmd_msb: assert property (st_q == ST_BIT && !rd_q && idx_q == 3'h1 // [R13]
    && bit_q == 4'h0 && ph_q == 2'h1 |-> sda_low_q == !cmd_q[15])
    else $error("command byte not sent as written");
  chk_stretch_wait: assert property (st_q == ST_BIT && ph_q == 2'h2 // [R1]
    && !scl_s && !scl_low_q |=> ph_q == 2'h2)
    else $error("stretched clock not waited for");
  chk_data_ack: assert property (st_q == ST_BIT && rd_q && idx_q != 3'h0 && slot // [R14]
    && ph_q == 2'h2 |-> sda_low_q == (idx_q != `HSC_LAST_RD))
    else $error("wrong acknowledge on read data");
  chk_crc_flag: assert property (done_q |=> crc_err_q == // [R12]
    ((crc_t != rx_q[31:24]) || (crc_h != rx_q[7:0])))
    else $error("checksum flag does not match data");

  cov_measure: cover property ($fell(st_q == ST_STOP) && !rd_q && !nack_q);
  cov_read: cover property (done_q);
  cov_nack: cover property ($rose(nack_q));
  cov_stretch: cover property (hold && st_q == ST_BIT);
  cov_reset: cover property ($rose(nrst_q));
endmodule // hsc_ctrl

/* core/hsc_consts.svh */
/*
  Named constants of the humidity sensor controller: clock rate, bus timing,
  sensor addresses, checksum polynomial, register offsets and field positions.
  Assumes a 200 MHz system clock and a sensor bus with external pull-ups.
*/
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HSC_CLK_MHZ 200
// One quarter of a 400 kHz serial clock period.
`define HSC_QTR_NS 625
`define HSC_QTR_CYC ((`HSC_QTR_NS * `HSC_CLK_MHZ) / 1000)
`define HSC_QTR_W 10
// Least width of the hard reset pulse, rounded up to whole cycles.
`define HSC_RST_NS 1000
`define HSC_RST_CYC ((`HSC_RST_NS * `HSC_CLK_MHZ + 999) / 1000)
// Least spacing between two commands, also used as the power-up wait.
`define HSC_GAP_NS 1000000
`define HSC_WAIT_W 18

// ----------------------------------------------------------------------------
// Sensor bus
// ----------------------------------------------------------------------------
`define HSC_ADDR_LO 7'h44
`define HSC_ADDR_HI 7'h45
`define HSC_LAST_WR 3'h2
`define HSC_LAST_RD 3'h6
`define HSC_BIT_ACK 4'h8
`define HSC_CRC_POLY 8'h31
`define HSC_CRC_INIT 8'hff

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define HSC_OFS_CTRL 32'h0000_0000
`define HSC_OFS_CMD 32'h0000_0004
`define HSC_OFS_STAT 32'h0000_0008
`define HSC_OFS_DATA 32'h0000_000c
`define HSC_CTRL_MEAS 0
`define HSC_CTRL_READ 1
`define HSC_CTRL_RST 2
`define HSC_CTRL_ASEL 4
`define HSC_RESP_OK 2'h0
`define HSC_RESP_ERR 2'h2

`endif

/* core/hsc_pkg.sv */
/*
  Types of the humidity sensor controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hsc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RST,
    ST_GAP,
    ST_START,
    ST_BIT,
    ST_STOP
  } hsc_state_t;
endpackage

/* core/hsc_sync.sv */
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes the input level stays put for several clock cycles.
*/
`timescale 1ns/1ps

module hsc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // hsc_sync

/* core/hsc_crc8.sv */
/*
  Eight-bit checksum over one sixteen-bit data word, most significant bit
  first. Assumes the caller registers the result where timing demands it.
*/
`timescale 1ns/1ps
`include "hsc_consts.svh"

module hsc_crc8 (
  input wire logic [15:0] data_i,
  output logic [7:0] crc_o
);
  always_comb begin
    logic [7:0] c;
    c = `HSC_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ data_i[i]) ? ((c << 1) ^ `HSC_CRC_POLY) : (c << 1);
    end
    crc_o = c;
  end
endmodule // hsc_crc8

/* bench/hsc_sensor_model.sv */
/*
  Behavioural humidity sensor on the far side of the serial bus.
  Assumes the bench resolves both lines from all pulls with pull-ups.
*/
`timescale 1ns/1ps

module hsc_sensor_model #(
  parameter int MEAS_NS = 200000,
  parameter int PU_NS = 200,
  parameter logic [15:0] TEMP_VAL = 16'h6666,
  parameter logic [15:0] HUM_VAL = 16'h8a3c,
  parameter logic [15:0] LIMIT = 16'h6000
) (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_pin_i,
  input wire logic hard_reset_input_low_i,
  output logic scl_pull_o,
  output logic sda_pull_o,
  output logic limit_alarm_output_o
);
  logic have_data = 1'b0;
  logic measuring = 1'b0;
  logic stretch_mode = 1'b0;
  logic stretched = 1'b0;
  logic [15:0] last_cmd = 16'h0000;
  realtime t_fall = 0.0;
  realtime rst_low_ns = 0.0;
  realtime ready_at = 0.0;

  // Alarm follows the latest result only, so it stays low until one exists.
  assign limit_alarm_output_o = have_data && (TEMP_VAL >= LIMIT);

  always @(negedge hard_reset_input_low_i) t_fall = $realtime;
  always @(posedge hard_reset_input_low_i) begin
    rst_low_ns = $realtime - t_fall;
    ready_at = $realtime + PU_NS;
    have_data = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction

  task automatic get_byte(output logic [7:0] b);
    repeat (8) begin
      @(posedge scl_i);
      b = {b[6:0], sda_i};
    end
  endtask

  task automatic ack();
    @(negedge scl_i);
    sda_pull_o = 1'b1;
    @(negedge scl_i);
    sda_pull_o = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic mack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull_o = !b[i];
      @(negedge scl_i);
    end
    sda_pull_o = 1'b0;
    @(posedge scl_i);
    mack = !sda_i;
    @(negedge scl_i);
  endtask

  // Event driven, so any serial clock rate and any stretch is followed.
  initial begin : engine
    logic [7:0] hdr;
    logic [7:0] b1;
    logic [7:0] b2;
    logic ok;
    logic [47:0] pk;
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    forever begin
      @(negedge sda_i iff scl_i === 1'b1);
      get_byte(hdr);
      if (hdr[7:1] != {6'h22, addr_pin_i} || $realtime < ready_at) begin
      end else if (!hdr[0]) begin
        ack();
        get_byte(b1);
        ack();
        get_byte(b2);
        last_cmd = {b1, b2};
        stretch_mode = (b1 == 8'h2c);
        measuring = 1'b1;
        have_data = 1'b0;
        fork
          begin
            #(MEAS_NS);
            measuring = 1'b0;
            have_data = 1'b1;
          end
        join_none
        ack();
      end else if (have_data || (measuring && stretch_mode)) begin
        ack();
        if (!have_data) begin
          stretched = 1'b1;
          scl_pull_o = 1'b1;
          wait (have_data);
          sda_pull_o = !TEMP_VAL[15];
          #50;
          scl_pull_o = 1'b0;
        end
        pk = {TEMP_VAL, crc8(TEMP_VAL), HUM_VAL, crc8(HUM_VAL)};
        ok = 1'b1;
        for (int k = 0; k < 6 && ok; k++) put_byte(pk[47 - 8 * k -: 8], ok);
      end
      @(posedge sda_i iff scl_i === 1'b1);
    end
  end
endmodule // hsc_sensor_model

/* bench/test_hsc_ctrl.sv */
/*
  Self-checking bench of the humidity sensor controller with a sensor model.
  Assumes the controller's register map and a shortened command gap.
*/
`timescale 1ns/1ps
`include "hsc_consts.svh"

module test_hsc_ctrl;
  localparam logic [1:0] OK = `HSC_RESP_OK;
  localparam logic [1:0] ERR = `HSC_RESP_ERR;
  localparam logic [15:0] T_VAL = 16'h6666;
  localparam logic [15:0] H_VAL = 16'h8a3c;
  logic clock_i = 1'b0;
  logic rst_i = 1'b0;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic flip = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic scl_o, scl_oe, sda_o, sda_oe, asel, hard_reset_n, alarm, scl_pull, sda_pull;
  int miscompares = 0;
  int n_checks = 0;
  wire logic scl_line = !((scl_oe & ~scl_o) | scl_pull);
  wire logic sda_line = !((sda_oe & ~sda_o) | sda_pull);
  wire logic addr_pin = asel ^ flip;

  hsc_ctrl #(.GAP_CYC(50)) u_hsc_ctrl (
    .clock_i(clock_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .bus_address_select_o(asel), .hard_reset_input_low_o(hard_reset_n),
    .limit_alarm_output_i(alarm));

  // A short measurement keeps the run brief, yet outlasts the trip to the read header.
  hsc_sensor_model #(.MEAS_NS(60000), .TEMP_VAL(T_VAL), .HUM_VAL(H_VAL)) u_hsc_sensor_model (
    .scl_i(scl_line), .sda_i(sda_line), .addr_pin_i(addr_pin),
    .hard_reset_input_low_i(hard_reset_n), .scl_pull_o(scl_pull),
    .sda_pull_o(sda_pull), .limit_alarm_output_o(alarm));

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clock_i); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clock_i); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock_i); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    do rd(`HSC_OFS_STAT, d, r); while (d[0] !== 1'b0);
  endtask

  task automatic t_regs();
    logic [1:0] r;
    rchk(`HSC_OFS_CTRL, 32'h0, OK);
    rchk(`HSC_OFS_STAT, 32'h0, OK);
    rchk(32'h0000_0010, 32'h0, ERR);
    wr(`HSC_OFS_DATA, 32'h1, r);
    chk({30'h0, r}, {30'h0, ERR});
    wr(`HSC_OFS_CMD, 32'h0000_2c06, r);
    rchk(`HSC_OFS_CMD, 32'h0000_2c06, OK);
  endtask

  task automatic t_hard_reset();
    logic [1:0] r;
    wr(`HSC_OFS_CTRL, 32'h4, r);
    rchk(`HSC_OFS_STAT, 32'h1, OK);
    wait_idle();
    chk({31'h0, u_hsc_sensor_model.rst_low_ns >= 1000.0}, 32'h1);
    chk({31'h0, hard_reset_n}, 32'h1);
  endtask

  task automatic t_measure();
    logic [1:0] r;
    wr(`HSC_OFS_CTRL, 32'h10, r);
    wr(`HSC_OFS_CTRL, 32'h11, r);
    chk({31'h0, asel}, 32'h1);
    wr(`HSC_OFS_CTRL, 32'h11, r);
    chk({30'h0, r}, {30'h0, ERR});
    wait_idle();
    chk({16'h0, u_hsc_sensor_model.last_cmd}, 32'h2c06);
    rchk(`HSC_OFS_STAT, 32'h0, OK);
  endtask

  task automatic t_read();
    logic [1:0] r;
    wr(`HSC_OFS_CTRL, 32'h12, r);
    wait_idle();
    chk({31'h0, u_hsc_sensor_model.stretched}, 32'h1);
    rchk(`HSC_OFS_DATA, {T_VAL, H_VAL}, OK);
    rchk(`HSC_OFS_STAT, 32'h18, OK);
  endtask

  // The sensor's address pin is inverted here so the header cannot match.
  task automatic t_mismatch();
    logic [1:0] r;
    wr(`HSC_OFS_CMD, 32'h0000_2400, r);
    flip <= 1'b1;
    wr(`HSC_OFS_CTRL, 32'h1, r);
    chk({31'h0, asel}, 32'h0);
    wait_idle();
    chk({16'h0, u_hsc_sensor_model.last_cmd}, 32'h2c06);
    rchk(`HSC_OFS_STAT, 32'h1a, OK);
  endtask

  task automatic results();
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #400_000;
    miscompares++;
    results();
  end

  // Reset rises at time zero from its declared low, so every flop sees a real edge on it.
  initial begin
    rst_i <= 1'b1;
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs();
    t_hard_reset();
    t_measure();
    t_read();
    t_mismatch();
    results();
  end
endmodule // test_hsc_ctrl
